// ===== rtl/ulm_line_modem.v
// serial line format, break, parity, loopback and modem handshake control
// Notes on behaviour
// - divisor access bit 7 set steers offsets 0 and 1 to the baud divisor.
// - break bit 6 forces the serial output low except in loopback.
// - stick parity bit 5 sends and checks parity equal to inverted even-select.
// - even select bit 4: 0 odd count of ones, 1 even, data plus parity.
// - parity enable bit 3 adds a transmitted parity bit and checks received parity.
// - stop count bit 2: one stop, else 1.5 for 5-bit, two otherwise.
// - length field picks 5, 6, 7 or 8 data bits.
// - loopback holds the transmit pin high and feeds transmit into receive.
// - loopback ties terminal ready to set ready and request to clear.
// - loopback ties aux output two to carrier, aux output one to ring.
// - request-to-send control bit drives the request output.
// - terminal-ready control bit drives the terminal ready output.
// - status complement bits show looped outputs during loopback.
`timescale 1ns/1ps
`default_nettype none
`include "ulm_defs.vh"

module ulm_line_modem #(
  parameter DIV_W = 16
) (
  input wire clock,
  input wire rst,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_q,
  input wire [7:0] tx_data,
  input wire tx_valid,
  output wire tx_ready,
  output reg [7:0] rx_data_q,
  output reg rx_valid_q,
  output reg rx_parity_err_q,
  output reg rx_frame_err_q,
  output reg txd_q,
  input wire rxd,
  output reg rts_n_q,
  output reg dtr_n_q,
  input wire cts_n,
  input wire dsr_n,
  input wire dcd_n,
  input wire ri_n
);
  localparam S_IDLE = 3'd0;
  localparam S_START = 3'd1;
  localparam S_DATA = 3'd2;
  localparam S_PAR = 3'd3;
  localparam S_STOP = 3'd4;

  // parity bit for a character of the given length and parity flavour
  function par_calc;
    input [7:0] data;
    input [1:0] len;
    input even_sel;
    input stick;
    reg [7:0] masked;
    begin
      masked = data & (8'hff >> (2'h3 - len));
      if (stick) begin
        par_calc = ~even_sel;
      end else begin
        par_calc = even_sel ? (^masked) : ~(^masked);
      end
    end
  endfunction

  reg [7:0] line_fmt_q;
  reg [7:0] modem_line_q;
  reg [DIV_W-1:0] div_q;
  reg [DIV_W-1:0] baud_cnt_q;
  reg tick16_q;

  reg [2:0] tx_state_q;
  reg [5:0] tx_cnt_q;
  reg [2:0] tx_idx_q;
  reg [7:0] tx_shift_q;
  reg tx_par_q;
  reg [5:0] tx_fmt_q;
  reg tx_bit;
  reg [5:0] tx_limit;

  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  reg rxd_s1_q;
  reg rxd_s2_q;

  wire dlab;
  wire loop_on;
  wire tx_line;
  wire rx_line;
  wire [5:0] rx_fmt;
  wire [7:0] rx_data;
  wire rx_par;
  wire rx_ferr;
  wire rx_done;
  wire [7:0] modem_stat;
  wire tx_bit_end;

  assign dlab = line_fmt_q[`ULM_LF_DIV_ACCESS];
  assign loop_on = modem_line_q[`ULM_ML_LOOP];

  // register writes
  always @(posedge clock) begin
    if (rst) begin
      line_fmt_q <= `ULM_LINE_FMT_RESET;
      modem_line_q <= `ULM_MODEM_LINE_RESET;
      div_q <= `ULM_DIV_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `ULM_OFF_DIV_LO: if (dlab) div_q[7:0] <= reg_wdata;
        `ULM_OFF_DIV_HI: if (dlab) div_q[DIV_W-1:8] <= reg_wdata[DIV_W-9:0];
        `ULM_OFF_LINE_FMT: line_fmt_q <= reg_wdata;
        `ULM_OFF_MODEM_LINE: modem_line_q <= {3'h0, reg_wdata[4:0]};
        default: line_fmt_q <= line_fmt_q;
      endcase
    end
  end

  // register reads, data valid the cycle after the strobe
  always @(posedge clock) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ULM_OFF_DIV_LO: reg_rdata_q <= dlab ? div_q[7:0] : 8'h00;
        `ULM_OFF_DIV_HI: reg_rdata_q <= dlab ? div_q[DIV_W-1:8] : 8'h00;
        `ULM_OFF_LINE_FMT: reg_rdata_q <= line_fmt_q;
        `ULM_OFF_MODEM_STAT: reg_rdata_q <= modem_stat;
        default: reg_rdata_q <= 8'h00;
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // 16x baud enable; a divisor of zero stops the line
  always @(posedge clock) begin
    if (rst) begin
      baud_cnt_q <= {DIV_W{1'b0}};
      tick16_q <= 1'b0;
    end else if (div_q == {DIV_W{1'b0}}) begin
      baud_cnt_q <= {DIV_W{1'b0}};
      tick16_q <= 1'b0;
    end else if (baud_cnt_q >= div_q - {{(DIV_W-1){1'b0}}, 1'b1}) begin
      baud_cnt_q <= {DIV_W{1'b0}};
      tick16_q <= 1'b1;
    end else begin
      baud_cnt_q <= baud_cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
      tick16_q <= 1'b0;
    end
  end

  // transmit shift register
  assign tx_ready = (tx_state_q == S_IDLE);

  always @* begin
    tx_limit = `ULM_TICKS_PER_BIT;
    if (tx_state_q == S_STOP && tx_fmt_q[`ULM_LF_STOP_BIT_COUNT]) begin
      tx_limit = (tx_fmt_q[1:0] == 2'b00) ? `ULM_TICKS_STOP_ONE_HALF : `ULM_TICKS_STOP_TWO;
    end
  end

  always @* begin
    case (tx_state_q)
      S_START: tx_bit = 1'b0;
      S_DATA: tx_bit = tx_shift_q[0];
      S_PAR: tx_bit = tx_par_q;
      default: tx_bit = 1'b1;
    endcase
  end

  assign tx_bit_end = tick16_q && (tx_cnt_q == tx_limit - 6'h01);

  always @(posedge clock) begin
    if (rst) begin
      tx_state_q <= S_IDLE;
      tx_cnt_q <= 6'h00;
      tx_idx_q <= 3'h0;
      tx_shift_q <= 8'h00;
      tx_par_q <= 1'b0;
      tx_fmt_q <= 6'h00;
    end else if (tx_state_q == S_IDLE) begin
      tx_cnt_q <= 6'h00;
      if (tx_valid) begin
        tx_fmt_q <= line_fmt_q[5:0];
        tx_shift_q <= tx_data;
        tx_par_q <= par_calc(tx_data, line_fmt_q[1:0], line_fmt_q[`ULM_LF_EVEN], line_fmt_q[`ULM_LF_STICK]);
        tx_idx_q <= 3'h0;
        tx_state_q <= S_START;
      end
    end else if (tick16_q) begin
      tx_cnt_q <= tx_bit_end ? 6'h00 : tx_cnt_q + 6'h01;
      if (tx_bit_end) begin
        case (tx_state_q)
          S_START: tx_state_q <= S_DATA;
          S_DATA: begin
            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
            tx_idx_q <= tx_idx_q + 3'h1;
            if (tx_idx_q == {1'b1, tx_fmt_q[1:0]}) begin
              tx_state_q <= tx_fmt_q[`ULM_LF_PARITY_ENABLE] ? S_PAR : S_STOP;
            end
          end
          S_PAR: tx_state_q <= S_STOP;
          S_STOP: tx_state_q <= S_IDLE;
          default: tx_state_q <= S_IDLE;
        endcase
      end
    end
  end

  // internal serial line: break forces low, loopback keeps the pin idle
  assign tx_line = line_fmt_q[`ULM_LF_BREAK] ? 1'b0 : tx_bit;

  always @(posedge clock) begin
    if (rst) begin
      txd_q <= 1'b1;
      rts_n_q <= 1'b1;
      dtr_n_q <= 1'b1;
    end else begin
      txd_q <= loop_on ? 1'b1 : tx_line;
      rts_n_q <= ~modem_line_q[`ULM_ML_RTS];
      dtr_n_q <= ~modem_line_q[`ULM_ML_DTR];
    end
  end

  // pin synchronisers
  always @(posedge clock) begin
    if (rst) begin
      sync1_q <= 4'hf;
      sync2_q <= 4'hf;
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
    end else begin
      sync1_q <= {dcd_n, ri_n, dsr_n, cts_n};
      sync2_q <= sync1_q;
      rxd_s1_q <= rxd;
      rxd_s2_q <= rxd_s1_q;
    end
  end

  assign rx_line = loop_on ? tx_line : rxd_s2_q;

  // complement of the modem inputs, or the looped outputs
  assign modem_stat[`ULM_MS_DCD] = loop_on ? modem_line_q[`ULM_ML_AUX_TWO] : ~sync2_q[3];
  assign modem_stat[`ULM_MS_RI] = loop_on ? modem_line_q[`ULM_ML_AUX_ONE] : ~sync2_q[2];
  assign modem_stat[`ULM_MS_DSR] = loop_on ? modem_line_q[`ULM_ML_DTR] : ~sync2_q[1];
  assign modem_stat[`ULM_MS_CTS] = loop_on ? modem_line_q[`ULM_ML_RTS] : ~sync2_q[0];
  assign modem_stat[3:0] = 4'h0;

  ulm_rx u_rx (
    .clock(clock),
    .rst(rst),
    .tick16(tick16_q),
    .rx_line(rx_line),
    .fmt_in(line_fmt_q[5:0]),
    .fmt_q(rx_fmt),
    .data_q(rx_data),
    .par_q(rx_par),
    .frame_err_q(rx_ferr),
    .done_q(rx_done)
  );

  // received character, parity checked against the format it arrived in
  always @(posedge clock) begin
    if (rst) begin
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
      rx_parity_err_q <= 1'b0;
      rx_frame_err_q <= 1'b0;
    end else begin
      rx_valid_q <= rx_done;
      if (rx_done) begin
        rx_data_q <= rx_data;
        rx_frame_err_q <= rx_ferr;
        rx_parity_err_q <= rx_fmt[`ULM_LF_PARITY_ENABLE] &&
          (rx_par != par_calc(rx_data, rx_fmt[1:0], rx_fmt[`ULM_LF_EVEN], rx_fmt[`ULM_LF_STICK]));
      end
    end
  end
endmodule // ulm_line_modem

`default_nettype wire

// ===== common/ulm_defs.vh
// register offsets, field positions, reset values and timing counts for the line/modem control block
`ifndef ULM_DEFS_VH
`define ULM_DEFS_VH

`define ULM_OFF_DIV_LO 3'h0
`define ULM_OFF_DIV_HI 3'h1
`define ULM_OFF_LINE_FMT 3'h3
`define ULM_OFF_MODEM_LINE 3'h4
`define ULM_OFF_MODEM_STAT 3'h6

`define ULM_LINE_FMT_RESET 8'h03
`define ULM_MODEM_LINE_RESET 8'h00
`define ULM_DIV_RESET 16'h0000

`define ULM_LF_DIV_ACCESS 7
`define ULM_LF_BREAK 6
`define ULM_LF_STICK 5
`define ULM_LF_EVEN 4
`define ULM_LF_PARITY_ENABLE 3
`define ULM_LF_STOP_BIT_COUNT 2
`define ULM_LF_LEN_HI 1
`define ULM_LF_LEN_LO 0

`define ULM_ML_LOOP 4
`define ULM_ML_AUX_TWO 3
`define ULM_ML_AUX_ONE 2
`define ULM_ML_RTS 1
`define ULM_ML_DTR 0

`define ULM_MS_DCD 7
`define ULM_MS_RI 6
`define ULM_MS_DSR 5
`define ULM_MS_CTS 4

`define ULM_TICKS_PER_BIT 6'h10
`define ULM_TICKS_HALF_BIT 6'h08
`define ULM_TICKS_STOP_ONE_HALF 6'h18
`define ULM_TICKS_STOP_TWO 6'h20

`endif

// ===== rtl/ulm_rx.v
// receive shift register: samples a 16x oversampled serial line into characters
`timescale 1ns/1ps
`default_nettype none
`include "ulm_defs.vh"

module ulm_rx (
  input wire clock,
  input wire rst,
  input wire tick16,
  input wire rx_line,
  input wire [5:0] fmt_in,
  output reg [5:0] fmt_q,
  output reg [7:0] data_q,
  output reg par_q,
  output reg frame_err_q,
  output reg done_q
);
  localparam S_IDLE = 3'd0;
  localparam S_START = 3'd1;
  localparam S_DATA = 3'd2;
  localparam S_PAR = 3'd3;
  localparam S_STOP = 3'd4;

  reg [2:0] state_q;
  reg [5:0] cnt_q;
  reg [2:0] idx_q;
  wire [2:0] last_idx;
  wire mid_bit;

  assign last_idx = {1'b1, fmt_q[`ULM_LF_LEN_HI:`ULM_LF_LEN_LO]};
  assign mid_bit = (cnt_q == `ULM_TICKS_PER_BIT - 6'h01);

  always @(posedge clock) begin
    done_q <= 1'b0;
    if (rst) begin
      state_q <= S_IDLE;
      cnt_q <= 6'h00;
      idx_q <= 3'h0;
      fmt_q <= 6'h00;
      data_q <= 8'h00;
      par_q <= 1'b0;
      frame_err_q <= 1'b0;
    end else if (tick16) begin
      cnt_q <= mid_bit ? 6'h00 : cnt_q + 6'h01;
      case (state_q)
        S_IDLE: begin
          cnt_q <= 6'h00;
          if (!rx_line) begin
            state_q <= S_START;
            fmt_q <= fmt_in;
          end
        end
        S_START: begin
          if (cnt_q == `ULM_TICKS_HALF_BIT - 6'h01) begin
            cnt_q <= 6'h00;
            state_q <= rx_line ? S_IDLE : S_DATA;
            data_q <= 8'h00;
            idx_q <= 3'h0;
          end
        end
        S_DATA: begin
          if (mid_bit) begin
            data_q[idx_q] <= rx_line;
            idx_q <= idx_q + 3'h1;
            if (idx_q == last_idx) begin
              state_q <= fmt_q[`ULM_LF_PARITY_ENABLE] ? S_PAR : S_STOP;
            end
          end
        end
        S_PAR: begin
          if (mid_bit) begin
            par_q <= rx_line;
            state_q <= S_STOP;
          end
        end
        S_STOP: begin
          if (mid_bit) begin
            frame_err_q <= ~rx_line;
            done_q <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule // ulm_rx

`default_nettype wire

// ===== verif/ulm_line_modem_assertions.sv
// checker for the line format and modem control block
`timescale 1ns/1ps
`default_nettype none
module ulm_line_modem_assertions (
  input wire logic clock,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_valid_q,
  input wire logic rx_parity_err_q,
  input wire logic txd_q,
  input wire logic rts_n_q,
  input wire logic dtr_n_q
);
  logic [7:0] lf_q;
  logic [7:0] ml_q;
  // shadow copies of the two control registers
  always_ff @(posedge clock) begin
    if (rst) begin
      lf_q <= 8'h03;
      ml_q <= 8'h00;
    end else if (reg_wr && reg_addr == 3'h3) begin
      lf_q <= reg_wdata;
    end else if (reg_wr && reg_addr == 3'h4) begin
      ml_q <= {3'h0, reg_wdata[4:0]};
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  div_gate_a: assert property (reg_rd && reg_addr <= 3'h1 && !lf_q[7] |=> reg_rdata_q == 8'h00) else $error("div gate");
  lf_read_a: assert property (reg_rd && reg_addr == 3'h3 |=> reg_rdata_q == lf_q) else $error("lf read");
  brk_low_a: assert property (lf_q[6] && $past(lf_q[6], 3) && !ml_q[4] && !$past(ml_q[4], 3)
    |-> !txd_q) else $error("break");
  loop_high_a: assert property (ml_q[4] && $past(ml_q[4], 3) |-> txd_q) else $error("loop txd");
  rts_pin_a: assert property (!ml_q[4] && ml_q == $past(ml_q, 2) |-> rts_n_q == !ml_q[1]) else $error("rts");
  dtr_pin_a: assert property (!ml_q[4] && ml_q == $past(ml_q, 2) |-> dtr_n_q == !ml_q[0]) else $error("dtr");
  loop_stat_a: assert property (reg_rd && reg_addr == 3'h6 && ml_q[4] && ml_q == $past(ml_q, 3)
    |=> reg_rdata_q == {ml_q[3:2], ml_q[0], ml_q[1], 4'h0}) else $error("loop stat");
  tx_take_a: assert property (tx_valid && tx_ready |=> !tx_ready) else $error("tx take");
  cover property (tx_valid && tx_ready);
  cover property (rx_valid_q && rx_parity_err_q);
  cover property (reg_rd && reg_addr == 3'h6 && ml_q[4]);
endmodule // ulm_line_modem_assertions
bind ulm_line_modem ulm_line_modem_assertions u_chk (.clock(clock), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .rx_valid_q(rx_valid_q), .rx_parity_err_q(rx_parity_err_q), .txd_q(txd_q),
  .rts_n_q(rts_n_q), .dtr_n_q(dtr_n_q));
`default_nettype wire

// ===== verif/ulm_peer.sv
// serial peer: drives the receive line and the modem status pins
`timescale 1ns/1ps
`default_nettype none
module ulm_peer (
  input wire logic clock,
  output var logic rxd,
  output var logic cts_n,
  output var logic dsr_n,
  output var logic dcd_n,
  output var logic ri_n
);
  initial begin
    rxd = 1'b1;
    {dcd_n, ri_n, dsr_n, cts_n} = 4'hf;
  end
  task automatic modem(logic [3:0] v);
    @(posedge clock);
    {dcd_n, ri_n, dsr_n, cts_n} <= v;
  endtask
  // 8 data bits, given parity bit, given stop level; line returned to mark after
  task automatic send(logic [7:0] d, logic par, logic stp);
    logic [10:0] f;
    f = {stp, par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clock);
      rxd <= f[i];
      repeat (15) @(posedge clock);
    end
    @(posedge clock);
    rxd <= 1'b1;
  endtask
endmodule // ulm_peer
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the line format and modem control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] tx_data = 8'h2d;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tx_valid = 1'b0;
  logic [7:0] fmts [7] = '{8'h03, 8'h0b, 8'h1a, 8'h29, 8'h39, 8'h04, 8'h07};
  wire [7:0] reg_rdata_q;
  wire [7:0] rx_data_q;
  wire tx_ready, rx_valid_q, rx_parity_err_q, txd_q, rts_n_q, dtr_n_q, rxd, cts_n, dsr_n, dcd_n, ri_n;
  wire rx_frame_err_q;
  int err_count = 0;
  int tests_run = 0;
  ulm_line_modem u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data_q(rx_data_q), .rx_valid_q(rx_valid_q), .rx_parity_err_q(rx_parity_err_q),
    .rx_frame_err_q(rx_frame_err_q), .txd_q(txd_q), .rxd(rxd), .rts_n_q(rts_n_q), .dtr_n_q(dtr_n_q),
    .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n));
  ulm_peer u_peer (.clock(clock), .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n));
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(string nm, logic [11:0] got, logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [2:0] a, logic [7:0] exp, string nm);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata_q, exp);
  endtask
  task automatic rx_wait(logic [7:0] d, logic pe, logic fe);
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clock);
      #1;
      if (rx_valid_q === 1'b1) break;
    end
    if (i >= 400) err_count++;
    if (i >= 400) wrap_up();
    chk("rx_data", rx_data_q, d);
    chk("rx_par", rx_parity_err_q, pe);
    chk("rx_ferr", rx_frame_err_q, fe);
  endtask
  // mid marks a run with a format write in mid-frame that must not apply yet
  task automatic t_frame(logic [7:0] f, logic mid);
    int n, p, nb, c, e;
    logic [11:0] got, exp;
    n = 5 + f[1:0];
    p = f[3];
    nb = 2 + n + p;
    e = 16 * (nb - 1) + (f[2] ? (n == 5 ? 24 : 32) : 16);
    got = '1;
    exp = '1;
    for (c = 0; c < n; c++) exp[c + 1] = tx_data[c];
    exp[0] = 1'b0;
    if (p) exp[n + 1] = f[5] ? !f[4] : ^(tx_data & ~(8'hff << n)) ^ !f[4];
    wr(3'h3, f);
    tx_valid <= 1'b1;
    @(posedge clock);
    tx_valid <= 1'b0;
    for (c = 1; c < 400; c++) begin
      @(posedge clock);
      reg_wr <= mid && c == 40;
      reg_addr <= 3'h3;
      reg_wdata <= 8'h3c;
      #1;
      if (c % 16 == 9 && c / 16 < nb) got[c / 16] = txd_q;
      if (c > 2 && tx_ready) break;
    end
    if (c >= 400) err_count++;
    if (c >= 400) wrap_up();
    chk("frame", got, exp);
    chk("stop_len", c >= e && c <= e + 3, 1'b1);
    $display("frame %h done", f);
  endtask
  task automatic t_regs();
    rd(3'h3, 8'h03, "lf_reset");
    rd(3'h4, 8'h00, "ml_read");
    rd(3'h0, 8'h00, "div_hidden");
    wr(3'h3, 8'h83);
    wr(3'h1, 8'h12);
    rd(3'h1, 8'h12, "div_hi");
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h00);
    rd(3'h0, 8'h01, "div_lo");
    rd(3'h7, 8'h00, "unmapped");
    wr(3'h3, 8'h03);
    rd(3'h0, 8'h00, "div_hidden");
    $display("regs done");
  endtask
  task automatic t_rx();
    wr(3'h3, 8'h1b);
    fork
      u_peer.send(8'h5a, 1'b0, 1'b1);
      rx_wait(8'h5a, 1'b0, 1'b0);
    join
    fork
      u_peer.send(8'h5a, 1'b1, 1'b1);
      rx_wait(8'h5a, 1'b1, 1'b0);
    join
    // stop bit held low: frame error flagged, data still delivered
    fork
      u_peer.send(8'h5a, 1'b0, 1'b0);
      rx_wait(8'h5a, 1'b0, 1'b1);
    join
    $display("rx done");
  endtask
  task automatic t_loop();
    wr(3'h3, 8'h03);
    wr(3'h4, 8'h1f);
    repeat (4) @(posedge clock);
    rd(3'h6, 8'hf0, "loop_stat");
    tx_valid <= 1'b1;
    @(posedge clock);
    tx_valid <= 1'b0;
    rx_wait(8'h2d, 1'b0, 1'b0);
    wr(3'h4, 8'h13);
    repeat (4) @(posedge clock);
    rd(3'h6, 8'h30, "loop_stat");
    wr(3'h4, 8'h00);
    $display("loop done");
  endtask
  task automatic t_pins();
    wr(3'h4, 8'h01);
    repeat (3) @(posedge clock);
    #1 chk("pins", {dtr_n_q, rts_n_q}, 2'b01);
    wr(3'h4, 8'h02);
    u_peer.modem(4'he);
    repeat (4) @(posedge clock);
    #1 chk("pins", {dtr_n_q, rts_n_q}, 2'b10);
    rd(3'h6, 8'h10, "msr");
    wr(3'h3, 8'h43);
    repeat (3) @(posedge clock);
    #1 chk("brk", txd_q, 1'b0);
    wr(3'h3, 8'h03);
    repeat (3) @(posedge clock);
    #1 chk("brk_off", txd_q, 1'b1);
    $display("pins done");
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    foreach (fmts[i]) t_frame(fmts[i], i == 0);
    t_rx();
    t_loop();
    t_pins();
    wrap_up();
  end
endmodule // tb
`default_nettype wire
